// *** include/asq_map.svh ***
// register offsets, field positions, reset values and timing figures of the sequencer
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH
`define ASQ_CLK_MHZ          50
`define ASQ_REG_CFG0         8'h00
`define ASQ_REG_CFG1         8'h01
`define ASQ_REG_CHSEL        8'h02
`define ASQ_REG_GAIN         8'h03
`define ASQ_REG_TCFG         8'h04
`define ASQ_REG_STATUS       8'h05
`define ASQ_REG_LO           8'h06
`define ASQ_REG_HI           8'h07
`define ASQ_REG_ADC0         8'h10
`define ASQ_REG_TEMP0        8'h20
`define ASQ_CFG0_START       0
`define ASQ_CFG0_MODE        1
`define ASQ_CFG0_DATA_AVAIL_FLAG        2
`define ASQ_CFG1_RATE_LO     0
`define ASQ_CFG1_DIFF_LO     2
`define ASQ_RATE_RESET       2'b00
`define ASQ_TACQ0_NS         375
`define ASQ_TACQ1_NS         2375
`define ASQ_TACQ2_NS         6375
`define ASQ_TACQ3_NS         14375
`define ASQ_TCONV_NS         1625
`define ASQ_TDAV_NS          1000
`define ASQ_TSYNC_NS         4000
`define ASQ_SYNC_CYC         4
`define ASQ_NS_PER_US        1000
`define ASQ_T_STEP           16'sh0008
`endif

// *** include/asq_pkg.sv ***
// types shared by the converter sequencer
package asq_pkg;
	typedef enum logic [2:0] {
		ASQ_IDLE = 3'b000,
		ASQ_SYNC = 3'b001,
		ASQ_ACQ  = 3'b010,
		ASQ_CONV = 3'b011,
		ASQ_NEXT = 3'b100
	} asq_state_t;
	typedef struct packed {
		logic [3:0]  chan;
		logic [11:0] code;
		logic        valid;
	} asq_sample_t;
	typedef struct packed {
		logic [1:0]  sensor;
		logic [11:0] code;
		logic        valid;
	} asq_temp_t;
endpackage

// *** src/asq_sequencer.sv ***
// converter sequencer, handshake, alarms and temperature monitor with avalon slave
// Behaviour
// - single-ended straight binary, differential twos complement
// - rate code sets acquisition; conversion fixed
// - rate resets to 00; sets throughput
// - nonzero rate naps between conversions
// - per-channel rate divided by enabled count
// - auto uses rate; direct capped, trigger paced
// - trigger synchronised before channel sequence starts
// - direct done sets flag, pin low
// - result read or pin edge clears flag
// - auto pass emits one microsecond pin pulse
// - flag reads zero in auto mode
// - convert pin falling edge starts cycle
// - mid-conversion edge finishes channel, restarts
// - enabled channels converted in ascending order
// - out-of-range channels 0-3 and temperatures set alarm flags
// - alarm pin low after filtered out-of-range
// - gain bit selects one or two reference
// - disabled temperature sensors are skipped
// - temperature monitor loops continuously
// - each sensor result in own register
// - twelve-bit twos complement eighth degree
// - staged results copied together, defer on transfer
// - direct converts once; auto repeats
// - start bit triggers like pin edge
`timescale 1ns/1ps
`default_nettype none
`include "asq_map.svh"

module asq_sequencer #(
	parameter int NCH     = 16,
	parameter int NALM    = 4,
	parameter int ALM_CNT = 4
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_srst,
	input  wire logic                 i_ce,
	input  wire logic [7:0]           i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          i_avs_writedata,
	output logic      [31:0]          o_avs_readdata,
	output logic                      o_avs_waitrequest,
	input  wire logic                 i_convert_pin_n,
	output logic                      o_data_avail_pin_n,
	output logic                      o_alarm_n,
	output logic                      o_sample_start,
	output logic      [3:0]           o_sample_chan,
	output logic                      o_sample_diff,
	output logic                      o_sample_gain,
	output logic                      o_nap,
	input  wire asq_pkg::asq_sample_t i_sample,
	output logic                      o_temp_start,
	output logic      [1:0]           o_temp_sensor,
	input  wire asq_pkg::asq_temp_t   i_temp,
	input  wire logic                 i_xfer_busy
);
	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam int CONV_CYC = (`ASQ_TCONV_NS * `ASQ_CLK_MHZ + `ASQ_NS_PER_US - 1) / `ASQ_NS_PER_US;
	localparam int DAV_CYC  = (`ASQ_TDAV_NS * `ASQ_CLK_MHZ) / `ASQ_NS_PER_US;
	localparam int SYNC_CYC = (`ASQ_TSYNC_NS * `ASQ_CLK_MHZ) / `ASQ_NS_PER_US;
	localparam int ACQ0 = (`ASQ_TACQ0_NS * `ASQ_CLK_MHZ + `ASQ_NS_PER_US - 1) / `ASQ_NS_PER_US;
	localparam int ACQ1 = (`ASQ_TACQ1_NS * `ASQ_CLK_MHZ + `ASQ_NS_PER_US - 1) / `ASQ_NS_PER_US;
	localparam int ACQ2 = (`ASQ_TACQ2_NS * `ASQ_CLK_MHZ + `ASQ_NS_PER_US - 1) / `ASQ_NS_PER_US;
	localparam int ACQ3 = (`ASQ_TACQ3_NS * `ASQ_CLK_MHZ + `ASQ_NS_PER_US - 1) / `ASQ_NS_PER_US;
	// sync kept short (a few clocks) so triggers start well within the allowed window
	localparam logic [9:0] SYNC_C = 10'(`ASQ_SYNC_CYC);

	if (NCH != 16 || NALM != 4 || ALM_CNT < 1 || ALM_CNT > 15 || `ASQ_SYNC_CYC > SYNC_CYC)
	begin : g_chk
		$error("asq_sequencer: unsupported parameters");
	end

	// ------------------------------------------------------------
	// input synchroniser and trigger edge
	// ------------------------------------------------------------
	logic [2:0] cnv_sync_q, cnv_sync_d;
	always_comb
	begin
		cnv_sync_d = {cnv_sync_q[1:0], i_convert_pin_n};
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			cnv_sync_q <= 3'h7;
		else if (i_ce)
			cnv_sync_q <= cnv_sync_d;
	end
	// falling edge seen between second and third stage
	wire pin_fall = cnv_sync_q[2] & ~cnv_sync_q[1];

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic        mode_q, mode_d;          // 1 = auto
	logic [1:0]  rate_q, rate_d;
	logic [1:0]  diff_q, diff_d;
	logic [15:0] chsel_q, chsel_d;
	logic [15:0] gain_q, gain_d;
	logic [2:0]  tcfg_q, tcfg_d;
	logic [11:0] lo_q, lo_d, hi_q, hi_d;
	logic        data_avail_flag_q, data_avail_flag_d;
	logic [6:0]  almf_q, almf_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rack_q, rack_d;
	logic [11:0] tmp_q [NCH];
	logic [11:0] res_q [NCH];
	logic [11:0] temp_q [3];
	logic        copy_pend_q, copy_pend_d;

	wire bus_rd  = i_avs_read & ~rack_q;
	wire bus_wr  = i_avs_write;
	wire wr_cfg0 = bus_wr & (i_avs_address == `ASQ_REG_CFG0);
	wire start_bit = wr_cfg0 & i_avs_writedata[`ASQ_CFG0_START];
	wire mode_chg  = wr_cfg0 & (i_avs_writedata[`ASQ_CFG0_MODE] != mode_q);
	wire cfg_abort = mode_chg | (bus_wr & (i_avs_address == `ASQ_REG_CHSEL
		|| i_avs_address == `ASQ_REG_LO || i_avs_address == `ASQ_REG_HI));
	wire res_read  = bus_rd & (i_avs_address[7:4] == `ASQ_REG_ADC0 >> 4);
	wire trig      = pin_fall | (start_bit & ~mode_chg);

	// ------------------------------------------------------------
	// primary sequencer
	// ------------------------------------------------------------
	asq_pkg::asq_state_t st_q, st_d;
	logic [9:0] cnt_q, cnt_d;
	logic [3:0] ch_q, ch_d;
	logic       restart_q, restart_d;
	logic       pass_done;
	logic [9:0] acq_c;

	// lowest enabled channel at or above a start point
	function automatic logic [4:0] next_ch(input logic [15:0] sel, input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int k = NCH - 1; k >= 0; k--)
			if (sel[k] && 5'(k) >= from)
				r = 5'(k);
		return r;
	endfunction

	always_comb
	begin
		unique case (rate_q)
			2'b00: acq_c = 10'(ACQ0);
			2'b01: acq_c = 10'(ACQ1);
			2'b10: acq_c = 10'(ACQ2);
			2'b11: acq_c = 10'(ACQ3);
		endcase
	end

	logic [4:0] nx;
	always_comb
	begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		ch_d      = ch_q;
		restart_d = restart_q | (trig & (st_q == asq_pkg::ASQ_CONV));
		pass_done = 1'b0;
		nx        = next_ch(chsel_q, {1'b0, ch_q} + 5'h01);
		unique case (st_q)
			asq_pkg::ASQ_IDLE:
				if (trig)
				begin
					st_d  = asq_pkg::ASQ_SYNC;
					cnt_d = SYNC_C;
				end
			asq_pkg::ASQ_SYNC:
				if (cnt_q <= 10'h001)
				begin
					nx = next_ch(chsel_q, 5'h00);
					if (nx[4])
						st_d = asq_pkg::ASQ_IDLE;
					else
					begin
						ch_d  = nx[3:0];
						st_d  = asq_pkg::ASQ_ACQ;
						cnt_d = acq_c;
					end
				end
				else
					cnt_d = cnt_q - 10'h001;
			asq_pkg::ASQ_ACQ:
				if (trig)
				begin
					st_d  = asq_pkg::ASQ_SYNC;
					cnt_d = SYNC_C;
				end
				else if (cnt_q <= 10'h001)
				begin
					st_d  = asq_pkg::ASQ_CONV;
					cnt_d = 10'(CONV_CYC);
				end
				else
					cnt_d = cnt_q - 10'h001;
			asq_pkg::ASQ_CONV:
				// channel in progress completes on a trigger; only cfg_abort ends it early
				if (cnt_q <= 10'h001)
					st_d = asq_pkg::ASQ_NEXT;
				else
					cnt_d = cnt_q - 10'h001;
			asq_pkg::ASQ_NEXT:
				if (restart_q)
				begin
					restart_d = 1'b0;
					st_d      = asq_pkg::ASQ_SYNC;
					cnt_d     = SYNC_C;
				end
				else if (!nx[4])
				begin
					ch_d  = nx[3:0];
					st_d  = asq_pkg::ASQ_ACQ;
					cnt_d = acq_c;
				end
				else
				begin
					pass_done = 1'b1;
					// auto repeats the group at the rate period, direct waits for a trigger
					if (mode_q)
					begin
						nx    = next_ch(chsel_q, 5'h00);
						ch_d  = nx[3:0];
						st_d  = asq_pkg::ASQ_ACQ;
						cnt_d = acq_c;
					end
					else
						st_d = asq_pkg::ASQ_IDLE;
				end
			default:
				st_d = asq_pkg::ASQ_IDLE;
		endcase
		if (cfg_abort)
		begin
			st_d      = asq_pkg::ASQ_IDLE;
			restart_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			st_q      <= asq_pkg::ASQ_IDLE;
			cnt_q     <= 10'h000;
			ch_q      <= 4'h0;
			restart_q <= 1'b0;
		end
		else if (i_ce)
		begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			ch_q      <= ch_d;
			restart_q <= restart_d;
		end
	end

	// nap during acquisition at slower rates; conversion front end is pulsed per channel
	always_comb
	begin
		o_nap          = (rate_q != `ASQ_RATE_RESET) && (st_q != asq_pkg::ASQ_CONV);
		o_sample_start = (st_q == asq_pkg::ASQ_CONV) && (cnt_q == 10'(CONV_CYC));
		o_sample_chan  = ch_q;
		o_sample_diff  = (ch_q < 4'h4) && diff_q[ch_q[1]];
		o_sample_gain  = gain_q[ch_q];
	end

	// ------------------------------------------------------------
	// double-buffered results
	// ------------------------------------------------------------
	always_comb
		copy_pend_d = (copy_pend_q | pass_done) & i_xfer_busy;
	wire do_copy = (copy_pend_q | pass_done) & ~i_xfer_busy;

	for (genvar g = 0; g < NCH; g++)
	begin : g_res
		always_ff @(posedge i_clk_sys)
		begin
			if (i_srst)
			begin
				tmp_q[g] <= 12'h000;
				res_q[g] <= 12'h000;
			end
			else if (i_ce)
			begin
				if (i_sample.valid && i_sample.chan == 4'(g))
					tmp_q[g] <= i_sample.code;
				if (do_copy)
					res_q[g] <= tmp_q[g];
			end
		end
	end

	// ------------------------------------------------------------
	// data-available handshake
	// ------------------------------------------------------------
	logic [5:0] dav_cnt_q, dav_cnt_d;
	always_comb
	begin
		// set wins over a simultaneous clear
		data_avail_flag_d = data_avail_flag_q;
		if (res_read || pin_fall)
			data_avail_flag_d = 1'b0;
		if (do_copy && !mode_q)
			data_avail_flag_d = 1'b1;
		if (mode_q)
			data_avail_flag_d = 1'b0;
		dav_cnt_d = (dav_cnt_q != 6'h00) ? dav_cnt_q - 6'h01 : 6'h00;
		if (do_copy && mode_q)
			dav_cnt_d = 6'(DAV_CYC);
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			data_avail_flag_q      <= 1'b0;
			dav_cnt_q   <= 6'h00;
			copy_pend_q <= 1'b0;
		end
		else if (i_ce)
		begin
			data_avail_flag_q      <= data_avail_flag_d;
			dav_cnt_q   <= dav_cnt_d;
			copy_pend_q <= copy_pend_d;
		end
	end
	always_comb
		o_data_avail_pin_n = ~(data_avail_flag_q | (dav_cnt_q != 6'h00));

	// ------------------------------------------------------------
	// temperature monitor
	// ------------------------------------------------------------
	logic [1:0] ts_q, ts_d;
	logic       tbusy_q, tbusy_d;
	always_comb
	begin
		ts_d         = ts_q;
		tbusy_d      = tbusy_q;
		o_temp_start = 1'b0;
		if (!tbusy_q)
		begin
			if (tcfg_q[ts_q])
			begin
				o_temp_start = 1'b1;
				tbusy_d      = 1'b1;
			end
			else
				ts_d = (ts_q == 2'h2) ? 2'h0 : ts_q + 2'h1;
		end
		else if (i_temp.valid)
		begin
			tbusy_d = 1'b0;
			ts_d    = (ts_q == 2'h2) ? 2'h0 : ts_q + 2'h1;
		end
		o_temp_sensor = ts_q;
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			ts_q      <= 2'h0;
			tbusy_q   <= 1'b0;
			temp_q[0] <= 12'h000;
			temp_q[1] <= 12'h000;
			temp_q[2] <= 12'h000;
		end
		else if (i_ce)
		begin
			ts_q    <= ts_d;
			tbusy_q <= tbusy_d;
			if (tbusy_q && i_temp.valid && !i_xfer_busy && i_temp.sensor != 2'h3)
				temp_q[i_temp.sensor] <= i_temp.code;
		end
	end

	// ------------------------------------------------------------
	// alarms with consecutive-count filter
	// ------------------------------------------------------------
	logic [6:0] oor;
	logic [3:0] fcnt_q [7];
	for (genvar a = 0; a < 7; a++)
	begin : g_alm
		if (a < NALM)
		begin : g_adc
			assign oor[a] = (res_q[a] < lo_q) || (res_q[a] > hi_q);
		end
		else
		begin : g_tmp
			// temperatures are twos complement, so thresholds are taken as signed
			wire logic signed [11:0] v = temp_q[a - NALM];
			assign oor[a] = tcfg_q[a - NALM] && (v < $signed(lo_q) || v > $signed(hi_q));
		end
		always_ff @(posedge i_clk_sys)
		begin
			if (i_srst)
				fcnt_q[a] <= 4'h0;
			else if (i_ce)
				fcnt_q[a] <= !oor[a] ? 4'h0 : (fcnt_q[a] == 4'(ALM_CNT)) ? fcnt_q[a]
					: fcnt_q[a] + 4'h1;
		end
	end
	always_comb
		o_alarm_n = (almf_q == 7'h00);

	// ------------------------------------------------------------
	// avalon slave
	// ------------------------------------------------------------
	always_comb
	begin
		mode_d  = mode_q;
		rate_d  = rate_q;
		diff_d  = diff_q;
		chsel_d = chsel_q;
		gain_d  = gain_q;
		tcfg_d  = tcfg_q;
		lo_d    = lo_q;
		hi_d    = hi_q;
		almf_d  = almf_q;
		rdata_d = 32'h0000_0000;
		rack_d  = bus_rd;
		if (bus_wr)
			unique case (i_avs_address)
				`ASQ_REG_CFG0:  mode_d  = i_avs_writedata[`ASQ_CFG0_MODE];
				`ASQ_REG_CFG1:
				begin
					rate_d = i_avs_writedata[`ASQ_CFG1_RATE_LO +: 2];
					diff_d = i_avs_writedata[`ASQ_CFG1_DIFF_LO +: 2];
				end
				`ASQ_REG_CHSEL: chsel_d = i_avs_writedata[15:0];
				`ASQ_REG_GAIN:  gain_d  = i_avs_writedata[15:0];
				`ASQ_REG_TCFG:  tcfg_d  = i_avs_writedata[2:0];
				`ASQ_REG_STATUS: ;
				`ASQ_REG_LO:    lo_d    = i_avs_writedata[11:0];
				`ASQ_REG_HI:    hi_d    = i_avs_writedata[11:0];
				default: ;
			endcase
		// reading status clears alarm flags still not re-set this cycle
		if (bus_rd && i_avs_address == `ASQ_REG_STATUS)
			almf_d = 7'h00;
		if (bus_rd)
		begin
			if (i_avs_address[7:4] == `ASQ_REG_ADC0 >> 4)
				rdata_d = {20'h0_0000, res_q[i_avs_address[3:0]]};
			else if (i_avs_address >= `ASQ_REG_TEMP0 && i_avs_address < `ASQ_REG_TEMP0 + 8'h03)
				rdata_d = {{20{temp_q[i_avs_address[1:0]][11]}}, temp_q[i_avs_address[1:0]]};
			else
				unique case (i_avs_address)
					`ASQ_REG_CFG0:   rdata_d = {29'h0, data_avail_flag_q & ~mode_q, mode_q, 1'b0};
					`ASQ_REG_CFG1:   rdata_d = {28'h0, diff_q, rate_q};
					`ASQ_REG_CHSEL:  rdata_d = {16'h0000, chsel_q};
					`ASQ_REG_GAIN:   rdata_d = {16'h0000, gain_q};
					`ASQ_REG_TCFG:   rdata_d = {29'h0, tcfg_q};
					`ASQ_REG_STATUS: rdata_d = {25'h0, almf_q};
					`ASQ_REG_LO:     rdata_d = {20'h0_0000, lo_q};
					`ASQ_REG_HI:     rdata_d = {20'h0_0000, hi_q};
					default:         rdata_d = 32'h0000_0000;
				endcase
		end
		for (int a = 0; a < 7; a++)
			if (fcnt_q[a] == 4'(ALM_CNT))
				almf_d[a] = 1'b1;
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			mode_q  <= 1'b0;
			rate_q  <= `ASQ_RATE_RESET;
			diff_q  <= 2'b00;
			chsel_q <= 16'h0000;
			gain_q  <= 16'h0000;
			tcfg_q  <= 3'h7;
			lo_q    <= 12'h000;
			hi_q    <= 12'hfff;
			almf_q  <= 7'h00;
			rdata_q <= 32'h0000_0000;
			rack_q  <= 1'b0;
		end
		else if (i_ce)
		begin
			mode_q  <= mode_d;
			rate_q  <= rate_d;
			diff_q  <= diff_d;
			chsel_q <= chsel_d;
			gain_q  <= gain_d;
			tcfg_q  <= tcfg_d;
			lo_q    <= lo_d;
			hi_q    <= hi_d;
			almf_q  <= almf_d;
			rdata_q <= rdata_d;
			rack_q  <= rack_d;
		end
	end
	always_comb
	begin
		o_avs_readdata    = rdata_q;
		o_avs_waitrequest = i_avs_read & ~rack_q;
	end
endmodule
`default_nettype wire

// *** test/asq_front_model.sv ***
// behavioural converter front end answering sample and temperature requests
`timescale 1ns/1ps
`default_nettype none
module asq_front_model #(
	parameter int SDLY = 40,
	parameter int TDLY = 30
) (
	input  wire logic			i_clk_sys,
	input  wire logic			i_srst,
	input  wire logic			i_sample_start,
	input  wire logic [3:0]			i_sample_chan,
	input  wire logic			i_temp_start,
	input  wire logic [1:0]			i_temp_sensor,
	output var  asq_pkg::asq_sample_t	o_sample,
	output var  asq_pkg::asq_temp_t		o_temp
);
	int		scnt = 0;
	int		tcnt = 0;
	// +25, -25 and +50 degrees at one eighth degree per count
	logic [11:0]	tcodes [3] = '{12'h0C8, 12'hF38, 12'h190};
	initial
	begin
		o_sample = '0;
		o_temp = '0;
	end
	// code lines carry the inverse of the last value outside a valid cycle
	always @(posedge i_clk_sys)
	begin
		scnt <= i_srst ? 0 : (i_sample_start ? SDLY : (scnt > 0 ? scnt - 1 : 0));
		tcnt <= i_srst ? 0 : (i_temp_start ? TDLY : (tcnt > 0 ? tcnt - 1 : 0));
		if (i_sample_start)
			o_sample.chan <= i_sample_chan;
		if (i_temp_start)
			o_temp.sensor <= i_temp_sensor;
		o_sample.valid <= (scnt == 1);
		o_temp.valid <= (tcnt == 1);
		o_sample.code <= (scnt == 1) ? {o_sample.chan, 8'h5A} : ~o_sample.code;
		o_temp.code <= (tcnt == 1) ? tcodes[o_temp.sensor] : ~o_temp.code;
	end
endmodule
`default_nettype wire

// *** test/asq_seq_asserts.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module asq_seq_asserts #(
	parameter int NCH = 16,
	parameter int NALM = 4,
	parameter int ALM_CNT = 4
) (
	input wire logic	i_clk_sys,
	input wire logic	i_srst,
	input wire logic [7:0]	i_avs_address,
	input wire logic	i_avs_read,
	input wire logic	i_avs_write,
	input wire logic	o_avs_waitrequest,
	input wire logic	o_data_avail_pin_n,
	input wire logic	o_alarm_n,
	input wire logic	o_sample_start,
	input wire logic	o_nap,
	input wire logic	o_temp_start
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);
	// ----------------
	// steps of a read and port checks
	// ----------------
	sequence s_read_open;
		$rose(i_avs_read) ##1 i_avs_read;
	endsequence
	sequence s_result_read;
		i_avs_read && !o_avs_waitrequest && i_avs_address[7:4] == 4'h1;
	endsequence
	a_wait_first: assert property ($rose(i_avs_read) |-> o_avs_waitrequest)
		else $error("read answered in its first cycle");
	a_wait_second: assert property (s_read_open |-> !o_avs_waitrequest)
		else $error("read not answered in its second cycle");
	a_write_nowait: assert property (i_avs_write |-> !o_avs_waitrequest)
		else $error("write stalled");
	a_reset_pins: assert property ($fell(i_srst) |-> o_data_avail_pin_n && o_alarm_n)
		else $error("pins active right after reset");
	a_nap_idle: assert property (o_sample_start |-> !o_nap)
		else $error("nap while converting");
	a_sample_gap: assert property (o_sample_start |=> !o_sample_start [*8])
		else $error("conversion shorter than allowed");
	a_temp_gap: assert property (o_temp_start |=> !o_temp_start [*4])
		else $error("temperature starts too close");
	a_read_clear: assert property (s_result_read |-> ##[1:2] o_data_avail_pin_n)
		else $error("result read left data pin low");
endmodule
bind asq_sequencer asq_seq_asserts #(.NCH(NCH), .NALM(NALM), .ALM_CNT(ALM_CNT)) u_asq_seq_asserts (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
	.o_data_avail_pin_n(o_data_avail_pin_n), .o_alarm_n(o_alarm_n),
	.o_sample_start(o_sample_start), .o_nap(o_nap), .o_temp_start(o_temp_start));
`default_nettype wire

// *** test/tb_top.sv ***
// testbench driving the sequencer over its register bus and convert pin
`timescale 1ns/1ps
`default_nettype none
`include "asq_map.svh"
module tb_top;
	logic			i_clk_sys;
	logic			i_srst = 1'b1;
	logic [7:0]		addr = 8'h00;
	logic			rd = 1'b0;
	logic			wr = 1'b0;
	logic [31:0]		wdata = 32'h0;
	logic [31:0]		rdata;
	logic			wait_req;
	logic			convert_pin_n_n = 1'b1;
	logic			dav_n;
	logic			alarm_n;
	logic			s_start;
	logic [3:0]		s_chan;
	logic			s_diff;
	logic			s_gain;
	logic			nap;
	logic			t_start;
	logic [1:0]		t_sensor;
	logic			busy = 1'b0;
	asq_pkg::asq_sample_t	sample;
	asq_pkg::asq_temp_t	temp;
	logic [31:0]		v;
	int			n_fail = 0;
	int			check_count = 0;
	int			cyc = 0;
	int			low_len = 0;
	int			width = 0;
	int			nap_cnt = 0;
	int			n0;
	int			lat_max = (`ASQ_TSYNC_NS + `ASQ_TACQ0_NS) * `ASQ_CLK_MHZ / `ASQ_NS_PER_US + 4;
	int			tcnt [3] = '{0, 0, 0};
	int			t0 [3];
	int			per [4];
	int			naps [4];
	int			acq_ns [4] = '{`ASQ_TACQ0_NS, `ASQ_TACQ1_NS, `ASQ_TACQ2_NS, `ASQ_TACQ3_NS};
	int			q_chan [$];
	int			q_dg [$];
	int			q_at [$];

	asq_sequencer u_asq_sequencer (
		.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(1'b1), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req), .i_convert_pin_n(convert_pin_n_n), .o_data_avail_pin_n(dav_n),
		.o_alarm_n(alarm_n), .o_sample_start(s_start), .o_sample_chan(s_chan),
		.o_sample_diff(s_diff), .o_sample_gain(s_gain), .o_nap(nap), .i_sample(sample),
		.o_temp_start(t_start), .o_temp_sensor(t_sensor), .i_temp(temp), .i_xfer_busy(busy));
	asq_front_model u_asq_front_model (
		.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sample_start(s_start),
		.i_sample_chan(s_chan), .i_temp_start(t_start), .i_temp_sensor(t_sensor),
		.o_sample(sample), .o_temp(temp));

	initial
	begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// ----------------
	// port monitor and run ceiling
	// ----------------
	always @(posedge i_clk_sys)
	begin
		cyc <= cyc + 1;
		if (s_start)
		begin
			q_chan.push_back(s_chan);
			q_dg.push_back({s_diff, s_gain});
			q_at.push_back(cyc);
		end
		if (t_start)
			tcnt[t_sensor] <= tcnt[t_sensor] + 1;
		if (nap)
			nap_cnt <= nap_cnt + 1;
		low_len <= dav_n ? 0 : low_len + 1;
		if (dav_n && low_len != 0)
			width <= low_len;
		if (cyc == 40000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge i_clk_sys);
		while (wait_req !== 1'b0)
			@(posedge i_clk_sys);
		v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, v);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// a pulse long enough to pass the pin synchroniser
	task automatic pulse;
		@(posedge i_clk_sys);
		convert_pin_n_n <= 1'b0;
		idle(4);
		convert_pin_n_n <= 1'b1;
	endtask
	task automatic wait_dav(input logic lvl, input int max);
		int k;
		k = 0;
		while (dav_n !== lvl && k < max)
		begin
			@(posedge i_clk_sys);
			k++;
		end
		chk("data_avail_pin_n", {31'h0, lvl}, {31'h0, dav_n});
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------
	// main sequence
	// ----------------
	initial
	begin
		idle(5);
		i_srst <= 1'b0;
		rchk("cfg1", `ASQ_REG_CFG1, 32'h0);
		rchk("tcfg", `ASQ_REG_TCFG, 32'h7);
		rchk("unmapped", 8'h3F, 32'h0);
		bus(1'b1, `ASQ_REG_TCFG, 32'h5);
		idle(300);
		t0 = tcnt;
		idle(400);
		chk("skipped sensor", 0, tcnt[1] - t0[1]);
		chk("monitor loops", 1, tcnt[0] - t0[0] > 1 && tcnt[2] - t0[2] > 1);
		rchk("local temp", `ASQ_REG_TEMP0, 32'h0000_00C8);
		rchk("remote two temp", `ASQ_REG_TEMP0 + 8'h02, 32'h0000_0190);
		bus(1'b1, `ASQ_REG_TCFG, 32'h7);
		idle(400);
		rchk("remote one temp", `ASQ_REG_TEMP0 + 8'h01, 32'hFFFF_FF38);
		// direct pass over channels 0 and 2, copy held off by a transfer
		bus(1'b1, `ASQ_REG_GAIN, 32'h0000_0004);
		bus(1'b1, `ASQ_REG_CFG1, 32'h0000_0004);
		bus(1'b1, `ASQ_REG_CHSEL, 32'h0000_0005);
		q_chan.delete();
		q_dg.delete();
		busy <= 1'b1;
		pulse();
		idle(800);
		chk("held by transfer", 1, dav_n);
		busy <= 1'b0;
		wait_dav(1'b0, 50);
		chk("pass count", 2, q_chan.size());
		chk("first chan", 0, q_chan[0]);
		chk("second chan", 2, q_chan[1]);
		chk("chan0 diff gain", 2, q_dg[0]);
		chk("chan2 diff gain", 1, q_dg[1]);
		rchk("flag set", `ASQ_REG_CFG0, 32'h0000_0004);
		rchk("result 0", `ASQ_REG_ADC0, 32'h0000_005A);
		wait_dav(1'b1, 4);
		rchk("flag clear", `ASQ_REG_CFG0, 32'h0);
		rchk("result 2", `ASQ_REG_ADC0 + 8'h02, 32'h0000_025A);
		q_chan.delete();
		bus(1'b1, `ASQ_REG_CFG0, 32'h0000_0001);
		wait_dav(1'b0, 600);
		chk("start bit pass", 2, q_chan.size());
		rchk("result 2 again", `ASQ_REG_ADC0 + 8'h02, 32'h0000_025A);
		// second edge while channel 0 converts
		bus(1'b1, `ASQ_REG_CHSEL, 32'h0000_0003);
		q_chan.delete();
		pulse();
		while (q_chan.size() == 0)
			@(posedge i_clk_sys);
		pulse();
		wait_dav(1'b0, 800);
		chk("restart chan", 0, q_chan[1]);
		chk("next chan", 1, q_chan[2]);
		pulse();
		wait_dav(1'b1, 10);
		wait_dav(1'b0, 800);
		// channels 1 and 2 above a lowered high threshold; 1 keeps its earlier result
		bus(1'b1, `ASQ_REG_HI, 32'h0000_00FF);
		bus(1'b1, `ASQ_REG_CHSEL, 32'h0000_0005);
		pulse();
		wait_dav(1'b0, 800);
		idle(10);
		chk("alarm pin", 0, alarm_n);
		bus(1'b0, `ASQ_REG_STATUS, 32'h0);
		chk("status", 32'h0000_0006, v & 32'h0000_000F);
		rchk("result 0 low", `ASQ_REG_ADC0, 32'h0000_005A);
		// auto mode at every rate code
		bus(1'b1, `ASQ_REG_CHSEL, 32'h0000_0001);
		for (int r = 0; r < 4; r++)
		begin
			bus(1'b1, `ASQ_REG_CFG1, r);
			bus(1'b1, `ASQ_REG_CFG0, 32'h0000_0002);
			pulse();
			q_at.delete();
			n0 = nap_cnt;
			while (q_at.size() < 4)
				@(posedge i_clk_sys);
			per[r] = q_at[3] - q_at[2];
			naps[r] = nap_cnt - n0;
			bus(1'b0, `ASQ_REG_CFG0, 32'h0);
			chk("flag in auto", 0, v & 32'h0000_0004);
			chk("pulse width", `ASQ_TDAV_NS * `ASQ_CLK_MHZ / `ASQ_NS_PER_US, width);
			bus(1'b1, `ASQ_REG_CFG0, 32'h0);
		end
		// two channels halve the per-channel rate; trigger latency within the sync window plus rate 00 acquisition
		bus(1'b1, `ASQ_REG_CFG1, 32'h0);
		bus(1'b1, `ASQ_REG_CHSEL, 32'h0000_0003);
		bus(1'b1, `ASQ_REG_CFG0, 32'h0000_0002);
		n0 = cyc;
		pulse();
		q_at.delete();
		while (q_at.size() < 4)
			@(posedge i_clk_sys);
		chk("trigger latency", 1, q_at[0] - n0 <= lat_max);
		chk("channel period", 2 * per[0], q_at[3] - q_at[1]);
		for (int r = 0; r < 4; r++)
		begin
			chk("nap", r != 0, naps[r] != 0);
			chk("rate step", (acq_ns[r] - acq_ns[0]) * `ASQ_CLK_MHZ / `ASQ_NS_PER_US, per[r] - per[0]);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
